/* File: core/ivm_arb.sv */
// picks the winning irq among pending enabled requests
`timescale 1ns/1ns
module ivm_arb
   import ivm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [19:0] req,
   input wire logic [19:0][1:0] prio,
   output logic found,
   output logic [4:0] win_irq
);
   logic better;

   always_comb
   begin
      found = 1'b0;
      win_irq = 5'h00;
      for (int lvl = 0; lvl < IVM_NUM_LVL; lvl++)
      begin
         for (int i = 0; i < IVM_NUM_IRQ; i++)
         begin
            if (!found && req[i] && prio[i] == 2'(lvl))
            begin
               found = 1'b1;
               win_irq = 5'(i);
            end
         end
      end
   end

   // helper for the check below only
   always_comb
   begin
      better = 1'b0;
      for (int i = 0; i < IVM_NUM_IRQ; i++)
      begin
         if (req[i] && (prio[i] < prio[win_irq] ||
             (prio[i] == prio[win_irq] && 5'(i) < win_irq)))
            better = 1'b1;
      end
   end

   a_arb_lowest: assert property (
      @(posedge pclk) disable iff (!presetn)
      found |-> req[win_irq] && !better)
      else $error("arbiter winner is not the best request");
   a_arb_none: assert property (
      @(posedge pclk) disable iff (!presetn)
      (req != 20'h0_0000) |-> found)
      else $error("arbiter missed a pending request");
endmodule

/* File: core/ivm_pkg.sv */
// constants, types and helpers for the interrupt priority and vector map
package ivm_pkg;

   localparam int IVM_NUM_IRQ = 20;
   localparam int IVM_NUM_LVL = 4;
   localparam int IVM_PRIO_W = 2;
   localparam int IVM_NUM_WORDS = 5;
   localparam int IVM_IRQS_PER_WORD = 4;
   localparam int IVM_FIELD_STEP = 8;
   localparam int IVM_FIELD_BASE = 6;

   // register byte offsets
   localparam logic [7:0] IVM_OFF_PRIO0 = 8'h00;
   localparam logic [7:0] IVM_OFF_ENABLE = 8'h20;
   localparam logic [7:0] IVM_OFF_PEND = 8'h24;
   localparam logic [7:0] IVM_OFF_CTRL = 8'h28;
   localparam logic [7:0] IVM_OFF_STAT = 8'h2C;
   localparam logic [7:0] IVM_OFF_STACK = 8'h30;

   localparam logic [31:0] IVM_PRIO_MASK = 32'hC0C0_C0C0;
   localparam logic [31:0] IVM_PRIO_RST = 32'h0000_0000;
   localparam logic [19:0] IVM_ENABLE_RST = 20'h0_0000;
   localparam logic IVM_CTRL_RST = 1'b0;

   localparam logic [5:0] IVM_IRQ_VEC_BASE = 6'h10;
   localparam logic [31:0] IVM_VT_BASE = 32'h0000_0000;
   localparam logic [31:0] IVM_VT_ENTRY = 32'h0000_0004;
   localparam logic [5:0] IVM_VEC_NMI = 6'h02;
   localparam logic [5:0] IVM_VEC_HARD = 6'h03;
   localparam logic [5:0] IVM_VEC_SVC = 6'h0B;
   localparam logic [5:0] IVM_VEC_PENDSV = 6'h0E;
   localparam logic [5:0] IVM_VEC_TICK = 6'h0F;

   typedef enum logic [1:0] {
      IVM_IDLE = 2'b01,
      IVM_OFFER = 2'b10
   } ivm_state_t;

   function automatic int ivm_field_pos(input int irq);
      return IVM_FIELD_STEP * (irq % IVM_IRQS_PER_WORD) + IVM_FIELD_BASE;
   endfunction

   function automatic logic [1:0] ivm_prio_of(
      input logic [4:0][31:0] w,
      input int irq
   );
      return w[irq / IVM_IRQS_PER_WORD][ivm_field_pos(irq) +: IVM_PRIO_W];
   endfunction

   function automatic logic [31:0] ivm_vec_addr(input logic [5:0] v);
      return IVM_VT_BASE + {26'h000_0000, v} * IVM_VT_ENTRY;
   endfunction

endpackage

/* File: core/ivm_sync.sv */
// two-stage synchroniser for an asynchronous pin
`timescale 1ns/1ns
module ivm_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

/* File: core/ivm_top.sv */
// interrupt priority store, source map and vector offer to the core
`timescale 1ns/1ns
module ivm_top
   import ivm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_pin_n,
   input wire logic dma_ch0_done,
   input wire logic dma_ch0_err,
   input wire logic dma_ch1_done,
   input wire logic dma_ch1_err,
   input wire logic dma_ch2_done,
   input wire logic dma_ch2_err,
   input wire logic dma_ch3_done,
   input wire logic dma_ch3_err,
   input wire logic flash_cmd_done,
   input wire logic flash_rd_collision,
   input wire logic pmc_lv_detect,
   input wire logic pmc_lv_warning,
   input wire logic low_leakage_wakeup_unit_wakeup,
   input wire logic i2c0_req,
   input wire logic i2c1_req,
   input wire logic spi0_req,
   input wire logic spi1_req,
   input wire logic uart0_req,
   input wire logic uart1_req,
   input wire logic uart2_req,
   input wire logic adc0_req,
   input wire logic analog_comparator_0_req,
   input wire logic timer0_req,
   input wire logic timer1_req,
   input wire logic timer2_req,
   input wire logic hard_fault_req,
   input wire logic svc_req,
   input wire logic pendsv_req,
   input wire logic system_tick_timer_req,
   input wire logic core_ack,
   output logic exc_req,
   output logic [5:0] exc_vec,
   output logic [31:0] exc_addr,
   output logic [5:0] stacked_vec
);
   // ------------------------------------------------------------
   // request line map
   // ------------------------------------------------------------
   logic [19:0] irq_line;

   always_comb
   begin
      irq_line[0] = dma_ch0_done | dma_ch0_err;
      irq_line[1] = dma_ch1_done | dma_ch1_err;
      irq_line[2] = dma_ch2_done | dma_ch2_err;
      irq_line[3] = dma_ch3_done | dma_ch3_err;
      irq_line[4] = 1'b0;
      irq_line[5] = flash_cmd_done | flash_rd_collision;
      irq_line[6] = pmc_lv_detect | pmc_lv_warning;
      irq_line[7] = low_leakage_wakeup_unit_wakeup;
      irq_line[8] = i2c0_req;
      irq_line[9] = i2c1_req;
      irq_line[10] = spi0_req;
      irq_line[11] = spi1_req;
      irq_line[12] = uart0_req;
      irq_line[13] = uart1_req;
      irq_line[14] = uart2_req;
      irq_line[15] = adc0_req;
      irq_line[16] = analog_comparator_0_req;
      irq_line[17] = timer0_req;
      irq_line[18] = timer1_req;
      irq_line[19] = timer2_req;
   end

   // ------------------------------------------------------------
   // register file over apb
   // ------------------------------------------------------------
   logic [4:0][31:0] prio_ff;
   logic [4:0][31:0] nxt_prio;
   logic [19:0] enable_ff;
   logic [19:0] nxt_enable;
   logic nmi_func_ff;
   logic nxt_nmi_func;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] rd_val;
   logic [2:0] pidx;
   logic prio_hit;
   logic mapped;
   logic apb_wr;
   logic apb_setup;
   logic [19:0] pend;
   ivm_state_t state_ff;
   ivm_state_t nxt_state;
   logic [5:0] vec_ff;
   logic [5:0] nxt_vec;
   logic [5:0] stack_ff;
   logic [5:0] nxt_stack;
   logic offer;

   assign pidx = paddr[4:2];
   assign prio_hit = (paddr[1:0] == 2'h0) &&
      (paddr < IVM_OFF_PRIO0 + 8'(IVM_NUM_WORDS * 4));
   assign mapped = prio_hit || paddr == IVM_OFF_ENABLE ||
      paddr == IVM_OFF_PEND || paddr == IVM_OFF_CTRL ||
      paddr == IVM_OFF_STAT || paddr == IVM_OFF_STACK;
   assign apb_wr = psel && penable && pwrite && mapped;
   assign apb_setup = psel && !penable;
   assign offer = (state_ff == IVM_OFFER);
   assign pend = irq_line & enable_ff;

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (prio_hit)
         rd_val = prio_ff[pidx] & IVM_PRIO_MASK;
      else
      begin
         case (paddr)
            IVM_OFF_ENABLE: rd_val = {12'h000, enable_ff};
            IVM_OFF_PEND: rd_val = {12'h000, pend};
            IVM_OFF_CTRL: rd_val = {31'h0000_0000, nmi_func_ff};
            IVM_OFF_STAT: rd_val = {23'h00_0000, offer, 2'h0, vec_ff};
            IVM_OFF_STACK: rd_val = {26'h000_0000, stack_ff};
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      nxt_prio = prio_ff;
      nxt_enable = enable_ff;
      nxt_nmi_func = nmi_func_ff;
      nxt_rdata = rdata_ff;
      if (apb_wr && prio_hit)
         nxt_prio[pidx] = pwdata & IVM_PRIO_MASK;
      if (apb_wr && paddr == IVM_OFF_ENABLE)
         nxt_enable = pwdata[19:0];
      if (apb_wr && paddr == IVM_OFF_CTRL)
         nxt_nmi_func = pwdata[0];
      // read data is caught in setup so it leaves a flip-flop
      if (apb_setup)
         nxt_rdata = rd_val;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prio_ff <= {IVM_NUM_WORDS{IVM_PRIO_RST}};
         enable_ff <= IVM_ENABLE_RST;
         nmi_func_ff <= IVM_CTRL_RST;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         prio_ff <= nxt_prio;
         enable_ff <= nxt_enable;
         nmi_func_ff <= nxt_nmi_func;
         rdata_ff <= nxt_rdata;
      end
   end

   assign prdata = rdata_ff;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ------------------------------------------------------------
   // non-maskable request
   // ------------------------------------------------------------
   logic nmi_sync;
   logic nmi_prev_ff;
   logic nmi_pend_ff;
   logic nxt_nmi_pend;
   logic nmi_set;
   logic nmi_clr;

   ivm_sync #(
      .RST_VAL(1'b1)
   ) u_nmi_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(nmi_pin_n),
      .sync_out(nmi_sync)
   );

   // the pin only reaches the core while its function is selected
   assign nmi_set = nmi_func_ff && nmi_prev_ff && !nmi_sync;
   assign nmi_clr = offer && core_ack && vec_ff == IVM_VEC_NMI;

   always_comb
   begin
      nxt_nmi_pend = nmi_pend_ff;
      if (nmi_clr)
         nxt_nmi_pend = 1'b0;
      // a new edge in the clearing cycle is kept
      if (nmi_set)
         nxt_nmi_pend = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nmi_prev_ff <= 1'b1;
         nmi_pend_ff <= 1'b0;
      end
      else
      begin
         nmi_prev_ff <= nmi_sync;
         nmi_pend_ff <= nxt_nmi_pend;
      end
   end

   // ------------------------------------------------------------
   // arbitration and vector offer
   // ------------------------------------------------------------
   logic [19:0][1:0] prio_vec;
   logic irq_found;
   logic [4:0] win_irq;
   logic sys_any;
   logic [5:0] win_vec;

   always_comb
   begin
      for (int i = 0; i < IVM_NUM_IRQ; i++)
         prio_vec[i] = ivm_prio_of(prio_ff, i);
   end

   ivm_arb u_arb (
      .pclk(pclk),
      .presetn(presetn),
      .req(pend),
      .prio(prio_vec),
      .found(irq_found),
      .win_irq(win_irq)
   );

   assign sys_any = nmi_pend_ff | hard_fault_req | svc_req |
      pendsv_req | system_tick_timer_req;

   // system handlers rank fixed above all peripheral lines
   always_comb
   begin
      if (nmi_pend_ff)
         win_vec = IVM_VEC_NMI;
      else if (hard_fault_req)
         win_vec = IVM_VEC_HARD;
      else if (svc_req)
         win_vec = IVM_VEC_SVC;
      else if (pendsv_req)
         win_vec = IVM_VEC_PENDSV;
      else if (system_tick_timer_req)
         win_vec = IVM_VEC_TICK;
      else
         win_vec = IVM_IRQ_VEC_BASE + {1'b0, win_irq};
   end

   // the offered vector is frozen until taken, so the core never
   // sees it change mid-fetch; a later, more urgent request waits
   always_comb
   begin
      nxt_state = state_ff;
      nxt_vec = vec_ff;
      nxt_stack = stack_ff;
      case (state_ff)
         IVM_IDLE:
         begin
            if (sys_any || irq_found)
            begin
               nxt_vec = win_vec;
               nxt_state = IVM_OFFER;
            end
         end
         IVM_OFFER:
         begin
            if (core_ack)
            begin
               nxt_stack = vec_ff;
               nxt_state = IVM_IDLE;
            end
         end
         default:
         begin
            nxt_state = IVM_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= IVM_IDLE;
         vec_ff <= 6'h00;
         stack_ff <= 6'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         vec_ff <= nxt_vec;
         stack_ff <= nxt_stack;
      end
   end

   assign exc_req = offer;
   assign exc_vec = vec_ff;
   assign exc_addr = ivm_vec_addr(vec_ff);
   assign stacked_vec = stack_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_prio_zero_bits: assert property (
      ((prio_ff[0] | prio_ff[1] | prio_ff[2] | prio_ff[3] | prio_ff[4])
      & ~IVM_PRIO_MASK) == 32'h0000_0000)
      else $error("priority word holds a reserved bit");
   a_nmi_edge_set: assert property (
      (nmi_func_ff && $fell(nmi_sync)) |=> nmi_pend_ff)
      else $error("nmi pin edge not latched");
   a_nmi_pin_gate: assert property (
      (!nmi_func_ff && !nmi_pend_ff) |=> !nmi_pend_ff)
      else $error("nmi raised with pin function off");
   a_stack_taken: assert property (
      (offer && core_ack) |=> stacked_vec == $past(exc_vec) && !exc_req)
      else $error("taken vector not stacked");
   a_irq_vec_num: assert property (
      (!offer && !sys_any && irq_found) |=>
      exc_req && exc_vec == 6'($past(win_irq)) + 6'h10)
      else $error("irq vector is not irq plus sixteen");
   a_vec_address: assert property (
      exc_addr == {24'h00_0000, exc_vec, 2'b00})
      else $error("vector address not four times vector");
   a_nmi_first: assert property (
      (!offer && nmi_pend_ff) |=> exc_req && exc_vec == 6'h02)
      else $error("nmi not offered first");
   a_offer_hold: assert property (
      (offer && !core_ack) |=> offer && $stable(exc_vec))
      else $error("offered vector changed before taken");
   a_bad_addr: assert property (
      (psel && penable && !mapped) |-> pslverr)
      else $error("unmapped access not flagged");
   a_field_pos: assert property (
      prio_vec[10] == prio_ff[2][23:22])
      else $error("irq 10 priority field misplaced");

   c_nmi_taken: cover property (offer && core_ack && exc_vec == 6'h02);
   c_irq_taken: cover property (offer && core_ack && exc_vec >= 6'h10);
   c_bad_addr: cover property (psel && penable && !mapped);
endmodule

/* File: tb/irq_priority_vector_map_test.sv */
// self-checking bench for the priority store and vector map
`timescale 1ns/1ns
module irq_priority_vector_map_test
   import ivm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, nmi_pin_n, core_ack;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, exc_addr;
   logic pready, pslverr, exc_req;
   logic [5:0] exc_vec, stacked_vec, last_vec;
   logic [28:0] req;
   logic [3:0] dly;
   int mismatches, n_tests;

   ivm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nmi_pin_n(nmi_pin_n), .dma_ch0_done(req[0]), .dma_ch0_err(req[1]),
      .dma_ch1_done(req[2]), .dma_ch1_err(req[3]), .dma_ch2_done(req[4]),
      .dma_ch2_err(req[5]), .dma_ch3_done(req[6]), .dma_ch3_err(req[7]),
      .flash_cmd_done(req[8]), .flash_rd_collision(req[9]),
      .pmc_lv_detect(req[10]), .pmc_lv_warning(req[11]),
      .low_leakage_wakeup_unit_wakeup(req[12]), .i2c0_req(req[13]), .i2c1_req(req[14]),
      .spi0_req(req[15]), .spi1_req(req[16]), .uart0_req(req[17]),
      .uart1_req(req[18]), .uart2_req(req[19]), .adc0_req(req[20]),
      .analog_comparator_0_req(req[21]), .timer0_req(req[22]), .timer1_req(req[23]),
      .timer2_req(req[24]), .hard_fault_req(req[25]), .svc_req(req[26]),
      .pendsv_req(req[27]), .system_tick_timer_req(req[28]), .core_ack(core_ack),
      .exc_req(exc_req), .exc_vec(exc_vec), .exc_addr(exc_addr),
      .stacked_vec(stacked_vec));

   ivm_core_model core_u (.pclk(pclk), .presetn(presetn),
      .exc_req(exc_req), .exc_vec(exc_vec), .dly(dly),
      .core_ack(core_ack), .last_vec(last_vec));

   // ------------------------------------------------------------
   // bus and compare helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
      chk(e, xe);
   endtask

   // sources that map onto irq lines, in the order of the req vector
   function automatic int irq_of(input int k);
      return (k < 8) ? k / 2 : (k < 10) ? 5 : (k < 12) ? 6 : k - 5;
   endfunction

   // waits for an offer, withdraws drop, waits for the core to take it
   task automatic serve(input logic [5:0] v, input logic [28:0] drop);
      int i;
      i = 0;
      @(negedge pclk);
      while (exc_req !== 1'b1 && i < 40)
      begin
         @(negedge pclk);
         i++;
      end
      chk(exc_req, 1'b1);
      chk(exc_vec, v);
      chk(exc_addr, {24'h00_0000, v, 2'b00});
      @(posedge pclk);
      req <= req & ~drop;
      i = 0;
      @(negedge pclk);
      while (exc_req === 1'b1 && i < 40)
      begin
         @(negedge pclk);
         i++;
      end
      chk(stacked_vec, v);
      chk(last_vec, v);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] p;
      rd(IVM_OFF_STAT, 32'h0000_0000, 1'b0);
      rd(IVM_OFF_STACK, 32'h0000_0000, 1'b0);
      rd(IVM_OFF_ENABLE, 32'h0000_0000, 1'b0);
      rd(IVM_OFF_CTRL, 32'h0000_0000, 1'b0);
      for (int w = 0; w < 5; w++)
      begin
         rd(IVM_OFF_PRIO0 + 8'(4 * w), 32'h0000_0000, 1'b0);
         wr(IVM_OFF_PRIO0 + 8'(4 * w), 32'hFFFF_FFFF);
         rd(IVM_OFF_PRIO0 + 8'(4 * w), 32'hC0C0_C0C0, 1'b0);
      end
      for (int l = 0; l < 4; l++)
      begin
         p = {4{l[1:0], 6'b00_0000}};
         wr(IVM_OFF_PRIO0 + 8'h0C, p);
         rd(IVM_OFF_PRIO0 + 8'h0C, p, 1'b0);
      end
      for (int w = 0; w < 5; w++)
         wr(IVM_OFF_PRIO0 + 8'(4 * w), 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000, 1'b1);
      wr(IVM_OFF_ENABLE, 32'hFFFF_FFFF);
      rd(IVM_OFF_ENABLE, 32'h000F_FFFF, 1'b0);
   endtask

   task automatic t_map();
      dly <= 4'h0;
      for (int k = 0; k < 25; k++)
      begin
         @(posedge pclk);
         req <= 29'h000_0001 << k;
         serve(6'(16 + irq_of(k)), 29'h1FFF_FFFF);
      end
   endtask

   task automatic t_prio();
      dly <= 4'h7;
      // irq 11 at level 2 loses to irq 12 at level 0
      wr(IVM_OFF_PRIO0 + 8'h08, 32'h8000_0000);
      @(posedge pclk);
      req <= 29'h003_0000;
      serve(6'd28, 29'h002_0000);
      serve(6'd27, 29'h001_0000);
      wr(IVM_OFF_PRIO0 + 8'h08, 32'h0000_0000);
      @(posedge pclk);
      req <= 29'h002_8000;
      serve(6'd26, 29'h000_8000);
      serve(6'd28, 29'h002_0000);
   endtask

   task automatic t_sys();
      dly <= 4'h2;
      @(posedge pclk);
      req <= 29'h1E02_0000;
      serve(IVM_VEC_HARD, 29'h0200_0000);
      serve(IVM_VEC_SVC, 29'h0400_0000);
      serve(IVM_VEC_PENDSV, 29'h0800_0000);
      serve(IVM_VEC_TICK, 29'h1000_0000);
      serve(6'd28, 29'h002_0000);
   endtask

   task automatic pulse_pin();
      @(posedge pclk);
      nmi_pin_n <= 1'b0;
      repeat (3) @(posedge pclk);
      nmi_pin_n <= 1'b1;
   endtask

   task automatic t_nmi();
      // with the pin function off an edge must leave no trace;
      // a slow core keeps a stray offer up until the check looks
      dly <= 4'hF;
      pulse_pin();
      repeat (8) @(negedge pclk);
      chk(exc_req, 1'b0);
      chk(stacked_vec, 6'd28);
      wr(IVM_OFF_CTRL, 32'h0000_0001);
      rd(IVM_OFF_CTRL, 32'h0000_0001, 1'b0);
      pulse_pin();
      serve(IVM_VEC_NMI, 29'h000_0000);
      // the stacked vector is read-only
      wr(IVM_OFF_STACK, 32'h0000_003F);
      rd(IVM_OFF_STACK, 32'h0000_0002, 1'b0);
      rd(IVM_OFF_STAT, 32'h0000_0002, 1'b0);
   endtask

   task automatic print_verdict();
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // clock, reset, sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial
   begin
      mismatches = 0;
      n_tests = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      nmi_pin_n = 1'b1;
      req = 29'h000_0000;
      dly = 4'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_map();
      t_prio();
      t_sys();
      t_nmi();
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end
endmodule

/* File: tb/ivm_core_model.sv */
// core-side model: takes each offered vector after a settable delay
`timescale 1ns/1ns
module ivm_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic exc_req,
   input wire logic [5:0] exc_vec,
   input wire logic [3:0] dly,
   output logic core_ack,
   output logic [5:0] last_vec
);
   logic [3:0] cnt_ff;
   // one ack per offer: the offer is gone the cycle after the ack edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_ack <= 1'b0;
         cnt_ff <= 4'h0;
         last_vec <= 6'h00;
      end
      else if (core_ack)
      begin
         core_ack <= 1'b0;
         cnt_ff <= 4'h0;
      end
      else if (exc_req)
      begin
         if (cnt_ff == dly)
         begin
            core_ack <= 1'b1;
            last_vec <= exc_vec;
         end
         else
            cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule
